// ---- core/mhf_pkg.sv ----
package mhf_pkg;
  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] MHF_CMD_READ = 8'h00;
  localparam logic [7:0] MHF_CMD_WRITE = 8'h08;
  // ---------------------------------------------------------------
  // frame byte positions (1-based, as sent)
  // ---------------------------------------------------------------
  localparam logic [3:0] MHF_OFS_TEMP_HI = 4'h1;
  localparam logic [3:0] MHF_OFS_TEMP_LO = 4'h2;
  localparam logic [3:0] MHF_OFS_RANGE = 4'h3;
  localparam logic [3:0] MHF_OFS_AVG = 4'h4;
  localparam logic [3:0] MHF_OFS_SETUP = 4'h5;
  localparam logic [3:0] MHF_OFS_COND = 4'h6;
  localparam logic [3:0] MHF_OFS_MAIN = 4'h7;
  localparam logic [3:0] MHF_OFS_REL = 4'h9;
  localparam logic [3:0] MHF_OFS_COMP = 4'hB;
  localparam logic [3:0] MHF_OFS_SERIAL = 4'hD;
  localparam logic [3:0] MHF_OFS_SUM = 4'hE;
  localparam logic [2:0] MHF_WR_LEN = 3'h7;
  // ---------------------------------------------------------------
  // limits and field positions
  // ---------------------------------------------------------------
  localparam logic [15:0] MHF_TEMP_MAX = 16'h01F4;
  localparam logic [7:0] MHF_RANGE_MAX = 8'h07;
  localparam logic [7:0] MHF_AVG_MAX = 8'h06;
  localparam int MHF_VIEW_LSB = 0;
  localparam int MHF_CURR_BIT = 2;
  localparam int MHF_LIGHT_BIT = 3;
  localparam int MHF_POL_BIT = 4;
  localparam int MHF_AUTO_BIT = 5;
  localparam int MHF_HOLD_BIT = 6;
  localparam int MHF_ZERO_BIT = 7;
  localparam int MHF_BIP_LSB = 0;
  localparam int MHF_OVL_LSB = 2;
  localparam int MHF_MSIGN_BIT = 4;
  localparam int MHF_RSIGN_BIT = 5;
  localparam int MHF_OPEN_BIT = 6;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] MHF_TEMP_RST = 16'h00C8;
  localparam logic [7:0] MHF_RANGE_RST = 8'h07;
  localparam logic [7:0] MHF_AVG_RST = 8'h00;
  localparam logic [7:0] MHF_SETUP_RST = 8'h20;
  localparam logic [1:0] MHF_VIEW_MAIN = 2'h0;
endpackage : mhf_pkg

// ---- core/mhf_sum8.sv ----
`timescale 1ns/100ps
// running 8-bit additive checksum
module mhf_sum8 (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic clr,
  input wire logic add,
  input wire logic [7:0] din,
  // result
  output logic [7:0] sum
);
  logic [7:0] sum_q;
  logic [7:0] sum_d;

  always_comb begin
    sum_d = sum_q;
    if (clr) begin
      sum_d = add ? din : 8'h00;
    end else if (add) begin
      sum_d = 8'(sum_q + din);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sum_q <= 8'h00;
    end else begin
      sum_q <= sum_d;
    end
  end

  assign sum = sum_q;
endmodule : mhf_sum8

// ---- core/mhf_setup_check.sv ----
`timescale 1ns/100ps
// validation of a received setup frame against the current setup
module mhf_setup_check
  import mhf_pkg::*;
(
  // received fields
  input wire logic [15:0] temp_in,
  input wire logic [7:0] range_in,
  input wire logic [7:0] avg_in,
  // current setup
  input wire logic [7:0] range_cur,
  // verdicts
  output logic temp_ok,
  output logic range_ok,
  output logic avg_ok,
  output logic range_change
);
  assign temp_ok = temp_in <= MHF_TEMP_MAX;
  assign range_ok = range_in <= MHF_RANGE_MAX;
  assign avg_ok = avg_in <= MHF_AVG_MAX;
  assign range_change = range_ok && (range_in != range_cur);
endmodule : mhf_setup_check

// ---- core/mhf_responder.sv ----
// How it works
// [R1] averaging code 0..6 in frame byte 4, read and writable
// [R2] setup_flags bits 1:0 hold the display view code
// [R3] setup_flags bits 2..5: current level, backlight, polarity, auto range
// [R4] setup_flags bit 6 frozen, bit 7 zeroing; whole byte writable
// [R5] condition_flags bits 1:0 hold bipolar state
// [R6] condition_flags read-only; bits 3:2 overload, bit 7 zero
// [R7] condition_flags bit 4 is main reading sign
// [R8] condition_flags bit 5 is relative reading sign
// [R9] condition_flags bit 6 set while current circuit open
// [R10] main reading sent big-endian in bytes 7 and 8
// [R11] relative reading sent big-endian in bytes 9 and 10
// [R12] compensated reading sent big-endian in bytes 11 and 12
// [R13] serial byte sent as byte 13
// [R14] byte 14 is low eight bits of sum of thirteen bytes
// [R15] host writes with 08H then the five setup bytes in order
// [R16] host always sends all five bytes plus checksum
// [R17] write frame: cmd, temp word, range, averaging, setup_flags, sum
// [R18] host should read before writing
// [R19] request byte 00H returns thirteen data bytes then checksum
// [R20] write checksum is sum of six bytes including command
// [R21] room temperature above 500 ignored, old value kept
// [R22] new range forces manual selection and main view
// [R23] write frame with bad checksum discarded
// [R24] unknown command bytes ignored
`timescale 1ns/100ps
module mhf_responder
  import mhf_pkg::*;
#(
  parameter logic [7:0] SERIAL_NUM = 8'h5A  // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // host receive byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // host transmit byte stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // instrument condition inputs
  input wire logic [1:0] bipolar_state,
  input wire logic [1:0] overload_state,
  input wire logic main_negative,
  input wire logic rel_negative,
  input wire logic circuit_open,
  input wire logic [15:0] main_value,
  input wire logic [15:0] rel_value,
  input wire logic [15:0] comp_value,
  // setup outputs to the instrument
  output logic [15:0] room_temp,
  output logic [7:0] range_code,
  output logic [7:0] avg_code,
  output logic [7:0] setup_flags,
  output logic setup_written
);
  import mhf_pkg::*;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MHF_IDLE = 3'b001,
    MHF_SEND = 3'b010,
    MHF_RECV = 3'b100
  } mhf_state_t;

  mhf_state_t st_q, st_d;
  logic [3:0] idx_q, idx_d;
  logic [7:0] frame_q [1:13];
  logic [7:0] frame_d [1:13];
  logic [7:0] wbuf_q [2:6];
  logic [7:0] wbuf_d [2:6];
  logic [7:0] tx_q, tx_d;
  logic txv_q, txv_d;
  logic [15:0] temp_q, temp_d;
  logic [7:0] range_q, range_d, avg_q, avg_d, setup_q, setup_d;
  logic wr_q, wr_d;
  logic [7:0] cond;
  logic [7:0] sum;
  logic sum_clr, sum_add;
  logic [7:0] sum_din;
  logic temp_ok, range_ok, avg_ok, range_change;
  logic rx_take, tx_take;
  logic frame_load;

  // ---------------------------------------------------------------
  // condition flags and response frame
  // ---------------------------------------------------------------
  always_comb begin
    cond = 8'h00;  // R6
    cond[MHF_BIP_LSB +: 2] = bipolar_state;  // R5
    cond[MHF_OVL_LSB +: 2] = overload_state;  // R6
    cond[MHF_MSIGN_BIT] = main_negative;  // R7
    cond[MHF_RSIGN_BIT] = rel_negative;  // R8
    cond[MHF_OPEN_BIT] = circuit_open;  // R9
  end

  // ---------------------------------------------------------------
  // frame snapshot taken when the read request is accepted
  // ---------------------------------------------------------------
  assign frame_load = rx_take && st_q == MHF_IDLE && rx_data == MHF_CMD_READ;

  always_comb begin
    frame_d = frame_q;
    if (frame_load) begin
      frame_d[MHF_OFS_TEMP_HI] = temp_q[15:8];
      frame_d[MHF_OFS_TEMP_LO] = temp_q[7:0];
      frame_d[MHF_OFS_RANGE] = range_q;
      frame_d[MHF_OFS_AVG] = avg_q;  // R1
      frame_d[MHF_OFS_SETUP] = setup_q;  // R2 R3 R4
      frame_d[MHF_OFS_COND] = cond;
      frame_d[MHF_OFS_MAIN] = main_value[15:8];  // R10
      frame_d[MHF_OFS_MAIN + 4'h1] = main_value[7:0];  // R10
      frame_d[MHF_OFS_REL] = rel_value[15:8];  // R11
      frame_d[MHF_OFS_REL + 4'h1] = rel_value[7:0];  // R11
      frame_d[MHF_OFS_COMP] = comp_value[15:8];  // R12
      frame_d[MHF_OFS_COMP + 4'h1] = comp_value[7:0];  // R12
      frame_d[MHF_OFS_SERIAL] = SERIAL_NUM;  // R13
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 1; i <= 13; i++) begin
        frame_q[i] <= 8'h00;
      end
    end else begin
      frame_q <= frame_d;
    end
  end

  // ---------------------------------------------------------------
  // checksum and write validation
  // ---------------------------------------------------------------
  mhf_sum8 u_sum (
    .clk(clk),
    .arst_n(arst_n),
    .clr(sum_clr),
    .add(sum_add),
    .din(sum_din),
    .sum(sum)
  );

  mhf_setup_check u_chk (
    .temp_in({wbuf_q[2], wbuf_q[3]}),
    .range_in(wbuf_q[4]),
    .avg_in(wbuf_q[5]),
    .range_cur(range_q),
    .temp_ok(temp_ok),
    .range_ok(range_ok),
    .avg_ok(avg_ok),
    .range_change(range_change)
  );

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  assign rx_ready = (st_q != MHF_SEND);
  assign rx_take = rx_valid && rx_ready;
  assign tx_take = txv_q && tx_ready;

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    tx_d = tx_q;
    txv_d = txv_q;
    wbuf_d = wbuf_q;
    wr_d = 1'b0;
    sum_clr = 1'b0;
    sum_add = 1'b0;
    sum_din = 8'h00;
    case (st_q)
      MHF_IDLE: begin
        if (rx_take) begin
          if (rx_data == MHF_CMD_READ) begin  // R19
            st_d = MHF_SEND;
            idx_d = 4'h0;
            sum_clr = 1'b1;
          end else if (rx_data == MHF_CMD_WRITE) begin  // R15
            st_d = MHF_RECV;
            idx_d = 4'h2;
            sum_clr = 1'b1;
            sum_add = 1'b1;  // R20
            sum_din = rx_data;
          end
          // R24
        end
      end
      MHF_SEND: begin
        if (!txv_q || tx_take) begin
          if (idx_q == MHF_OFS_SUM) begin
            txv_d = 1'b0;
            st_d = MHF_IDLE;
          end else begin
            idx_d = 4'(idx_q + 4'h1);
            txv_d = 1'b1;
            if (4'(idx_q + 4'h1) == MHF_OFS_SUM) begin
              tx_d = sum;  // R14
            end else begin
              tx_d = frame_q[4'(idx_q + 4'h1)];
              sum_add = 1'b1;  // R14
              sum_din = frame_q[4'(idx_q + 4'h1)];
            end
          end
        end
      end
      MHF_RECV: begin
        if (rx_take) begin
          if (idx_q == 4'(MHF_WR_LEN)) begin  // R16 R17
            st_d = MHF_IDLE;
            if (rx_data == sum) begin  // R20 R23
              wr_d = 1'b1;
            end
          end else begin
            wbuf_d[idx_q[2:0]] = rx_data;  // R17
            idx_d = 4'(idx_q + 4'h1);
            sum_add = 1'b1;  // R20
            sum_din = rx_data;
          end
        end
      end
      default: begin
        st_d = MHF_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= MHF_IDLE;
      idx_q <= 4'h0;
      tx_q <= 8'h00;
      txv_q <= 1'b0;
      for (int i = 2; i <= 6; i++) begin
        wbuf_q[i] <= 8'h00;
      end
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      tx_q <= tx_d;
      txv_q <= txv_d;
      wbuf_q <= wbuf_d;
    end
  end

  // ---------------------------------------------------------------
  // setup registers, updated by an accepted write frame
  // ---------------------------------------------------------------
  always_comb begin
    temp_d = temp_q;
    range_d = range_q;
    avg_d = avg_q;
    setup_d = setup_q;
    if (wr_d) begin
      if (temp_ok) begin  // R21
        temp_d = {wbuf_q[2], wbuf_q[3]};
      end
      if (range_ok) begin
        range_d = wbuf_q[4];
      end
      if (avg_ok) begin  // R1
        avg_d = wbuf_q[5];
      end
      setup_d = wbuf_q[6];  // R4
      if (range_change) begin  // R22
        setup_d[MHF_AUTO_BIT] = 1'b0;
        setup_d[MHF_VIEW_LSB +: 2] = MHF_VIEW_MAIN;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_q <= MHF_TEMP_RST;
      range_q <= MHF_RANGE_RST;
      avg_q <= MHF_AVG_RST;
      setup_q <= MHF_SETUP_RST;
      wr_q <= 1'b0;
    end else begin
      temp_q <= temp_d;
      range_q <= range_d;
      avg_q <= avg_d;
      setup_q <= setup_d;
      wr_q <= wr_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign tx_valid = txv_q;
  assign tx_data = tx_q;
  assign room_temp = temp_q;
  assign range_code = range_q;
  assign avg_code = avg_q;
  assign setup_flags = setup_q;
  assign setup_written = wr_q;
endmodule : mhf_responder

// ---- sim/mhf_responder_chk.sv ----
`timescale 1ns/100ps
module mhf_responder_chk
  import mhf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // byte streams
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  // setup
  input wire logic [15:0] room_temp,
  input wire logic [7:0] range_code,
  input wire logic [7:0] avg_code,
  input wire logic [7:0] setup_flags,
  input wire logic setup_written
);
  // ----------
  // write frame position
  // ----------
  logic [2:0] wr_q;
  logic [2:0] wr_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence rd_req;
    rx_valid && rx_ready && wr_q == 3'h0 && rx_data == MHF_CMD_READ;
  endsequence
  sequence wr_last;
    rx_valid && rx_ready && wr_q == 3'h6;
  endsequence
  always_comb begin
    wr_d = wr_q;
    if (rx_valid && rx_ready) begin
      if (wr_q != 3'h0) wr_d = (wr_q == 3'h6) ? 3'h0 : wr_q + 3'h1;
      else if (rx_data == MHF_CMD_WRITE) wr_d = 3'h1;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) wr_q <= 3'h0;
    else wr_q <= wr_d;
  end
  rd_start_a: assert property (rd_req |=> !tx_valid ##1 tx_valid && !rx_ready)
    else $error("read request not answered");
  rd_busy_a: assert property (rd_req |=> !rx_ready [*8])
    else $error("request taken during response");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("response byte not held");
  rdy_excl_a: assert property (tx_valid |-> !rx_ready)
    else $error("ready while sending");
  wr_done_a: assert property ($rose(setup_written) |-> $past(rx_valid && rx_ready && wr_q == 3'h6))
    else $error("setup pulse without frame end");
  wr_pulse_a: assert property (wr_last ##1 setup_written |=> !setup_written)
    else $error("setup pulse too long");
  setup_keep_a: assert property (!setup_written |-> $stable({room_temp, range_code, avg_code, setup_flags}))
    else $error("setup changed without write");
  temp_lim_a: assert property (room_temp <= MHF_TEMP_MAX)
    else $error("room temperature out of limit");
  avg_lim_a: assert property (avg_code <= MHF_AVG_MAX)
    else $error("averaging code out of limit");
  range_man_a: assert property (setup_written && range_code != $past(range_code) |-> !setup_flags[MHF_AUTO_BIT] && setup_flags[1:0] == MHF_VIEW_MAIN)
    else $error("range change kept auto or view");
endmodule : mhf_responder_chk

// ---- sim/mhf_host_model.sv ----
`timescale 1ns/100ps
module mhf_host_model
  import mhf_pkg::*;
(
  // clock
  input wire logic clk,
  // request stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // response stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  // ----------
  // host frames
  // ----------
  logic slow = 1'b0;
  logic sum_ok;
  logic [7:0] frame [1:14];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hFF;
    tx_ready = 1'b1;
  end
  // stalls every other cycle when slow
  always @(posedge clk) tx_ready <= slow ? ~tx_ready : 1'b1;
  task automatic put(input logic [7:0] b);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data = b;
    while (!rx_ready) @(negedge clk);
    @(posedge clk);
  endtask : put
  task automatic idle();
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask : idle
  task automatic rd_frame();
    logic [7:0] s;
    s = 8'h00;
    put(MHF_CMD_READ);
    idle();
    for (int i = 1; i <= 14; i++) begin
      while (!(tx_valid && tx_ready)) @(negedge clk);
      frame[i] = tx_data;
      if (i < 14) s = s + tx_data;
      @(negedge clk);
    end
    sum_ok = (s === frame[14]);
  endtask : rd_frame
  task automatic wr_frame(input logic [15:0] t, input logic [7:0] r, a, f, input logic bad);
    logic [7:0] s;
    s = MHF_CMD_WRITE + t[15:8] + t[7:0] + r + a + f + {7'h00, bad};
    put(MHF_CMD_WRITE);
    put(t[15:8]);
    put(t[7:0]);
    put(r);
    put(a);
    put(f);
    put(s);
    idle();
  endtask : wr_frame
endmodule : mhf_host_model

// ---- sim/meter_host_frame_responder_bench.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, b); end end
module meter_host_frame_responder_bench;
  import mhf_pkg::*;
  // ----------
  // stimulus and expectations
  // ----------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, setup_written;
  logic [7:0] rx_data, tx_data, range_code, avg_code, setup_flags;
  logic [15:0] room_temp;
  logic [1:0] bip = 2'h0;
  logic [1:0] ovl = 2'h0;
  logic mneg = 1'b0, rneg = 1'b0, opn = 1'b0;
  logic [15:0] mval = 16'h0000, rval = 16'h0000, cval = 16'h0000;
  logic [15:0] e_temp = MHF_TEMP_RST;
  logic [7:0] e_rng = MHF_RANGE_RST, e_avg = MHF_AVG_RST, e_flg = MHF_SETUP_RST;
  int n_errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  mhf_responder #(.SERIAL_NUM(8'hA5)) dut_u (.clk(clk), .arst_n(arst_n),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .bipolar_state(bip), .overload_state(ovl), .main_negative(mneg),
    .rel_negative(rneg), .circuit_open(opn), .main_value(mval), .rel_value(rval),
    .comp_value(cval), .room_temp(room_temp), .range_code(range_code),
    .avg_code(avg_code), .setup_flags(setup_flags), .setup_written(setup_written));
  mhf_host_model host_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // ----------
  // scenarios
  // ----------
  task automatic chk_frame(input logic [7:0] cond);
    host_u.rd_frame();
    `CHK({host_u.frame[1], host_u.frame[2]}, e_temp)
    `CHK(host_u.frame[3], e_rng)
    `CHK(host_u.frame[4], e_avg)
    `CHK(host_u.frame[5], e_flg)
    `CHK(host_u.frame[6], cond)
    `CHK({host_u.frame[7], host_u.frame[8]}, mval)
    `CHK({host_u.frame[9], host_u.frame[10]}, rval)
    `CHK({host_u.frame[11], host_u.frame[12]}, cval)
    `CHK(host_u.frame[13], 8'hA5)
    `CHK(host_u.sum_ok, 1'b1)
  endtask : chk_frame
  task automatic chk_setup(input logic w);
    `CHK(setup_written, w)
    `CHK(room_temp, e_temp)
    `CHK(range_code, e_rng)
    `CHK(avg_code, e_avg)
    `CHK(setup_flags, e_flg)
  endtask : chk_setup
  task automatic t_read();
    @(negedge clk);
    {bip, ovl, mneg, opn} = {2'h2, 2'h1, 1'b1, 1'b1};
    {mval, rval, cval} = {16'h54EF, 16'h006D, 16'h4256};
    chk_frame(8'h56);
    @(negedge clk);
    host_u.slow = 1'b1;
    {bip, ovl, mneg, rneg, opn} = {2'h1, 2'h2, 1'b0, 1'b1, 1'b0};
    {mval, rval, cval} = {16'hFFFF, 16'h8001, 16'h0100};
    chk_frame(8'h29);
    host_u.slow = 1'b0;
    $display("test read done");
  endtask : t_read
  task automatic t_write();
    chk_frame(8'h29);
    host_u.wr_frame(16'h0138, 8'h07, 8'h06, 8'hDF, 1'b0);
    {e_temp, e_avg, e_flg} = {16'h0138, 8'h06, 8'hDF};
    chk_setup(1'b1);
    chk_frame(8'h29);
    $display("test write done");
  endtask : t_write
  task automatic t_reject();
    host_u.put(8'h55);
    host_u.idle();
    host_u.wr_frame(16'h0000, 8'h01, 8'h00, 8'h00, 1'b1);
    chk_setup(1'b0);
    host_u.wr_frame(16'h01F5, 8'h03, 8'h07, 8'h23, 1'b0);
    {e_rng, e_flg} = {8'h03, 8'h00};
    chk_setup(1'b1);
    host_u.wr_frame(16'h01F4, 8'h03, 8'h06, 8'h21, 1'b0);
    {e_temp, e_flg} = {16'h01F4, 8'h21};
    chk_setup(1'b1);
    host_u.wr_frame(16'h01F4, 8'h09, 8'h02, 8'h2E, 1'b0);
    {e_avg, e_flg} = {8'h02, 8'h2E};
    chk_setup(1'b1);
    chk_frame(8'h29);
    $display("test reject done");
  endtask : t_reject
  task automatic t_reset();
    host_u.put(MHF_CMD_WRITE);
    host_u.put(8'h01);
    host_u.idle();
    arst_n = 1'b0;
    {e_temp, e_rng, e_avg, e_flg} = {MHF_TEMP_RST, MHF_RANGE_RST, MHF_AVG_RST, MHF_SETUP_RST};
    repeat (2) @(negedge clk);
    chk_setup(1'b0);
    arst_n = 1'b1;
    chk_frame(8'h29);
    $display("test reset done");
  endtask : t_reset
  task automatic stop_test();
    $display("compares %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (6) @(negedge clk);
    chk_setup(1'b0);
    arst_n = 1'b1;
    t_read();
    t_write();
    t_reject();
    t_reset();
    stop_test();
  end
  initial begin
    #50000;
    n_errors++;
    stop_test();
  end
endmodule : meter_host_frame_responder_bench
bind mhf_responder mhf_responder_chk chk_u (.clk(clk), .arst_n(arst_n),
  .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .room_temp(room_temp), .range_code(range_code),
  .avg_code(avg_code), .setup_flags(setup_flags), .setup_written(setup_written));
